/* mcc_defs.svh */
`ifndef MCC_DEFS_SVH
`define MCC_DEFS_SVH

// Register offsets as seen through the register pointer.
`define MCC_ADDR_CONFIG 8'h00
`define MCC_ADDR_STAT1 8'h01
`define MCC_ADDR_STAT2 8'h02
`define MCC_ADDR_MASK1 8'h03
`define MCC_ADDR_MASK2 8'h04
`define MCC_ADDR_FANDIV 8'h05
`define MCC_ADDR_OSCFG 8'h06
`define MCC_ADDR_CONVRATE 8'h07
`define MCC_ADDR_CHDIS 8'h08
`define MCC_ADDR_MFR_ID 8'h09
`define MCC_ADDR_REV_ID 8'h0A
`define MCC_ADDR_PTR 8'h0F
`define MCC_ADDR_RAM_LO 8'h20
`define MCC_ADDR_RAM_HI 8'h3F
`define MCC_ADDR_RAM_3E 8'h3E

// Configuration register field positions.
`define MCC_CFG_START 0
`define MCC_CFG_INT_EN 1
`define MCC_CFG_INT_POL 2
`define MCC_CFG_INT_CLR 3
`define MCC_CFG_RESET 4
`define MCC_CFG_CHASSIS 5
`define MCC_CFG_GPO 6
`define MCC_CFG_INIT 7

// Pin-function register field positions.
`define MCC_FD_OS_EN 6
`define MCC_FD_RST_EN 7

// Power-on values.
`define MCC_RST_CONFIG 8'h08
`define MCC_RST_STAT 8'h00
`define MCC_RST_MASK 8'h00
`define MCC_RST_FANDIV 8'h14
`define MCC_RST_OSCFG 8'h01
`define MCC_RST_CONVRATE 8'h00
`define MCC_RST_CHDIS 8'h00
`define MCC_RST_RAM 8'h00
`define MCC_RST_RAM_3E 8'h01
`define MCC_RST_RAM_3F 8'h08
`define MCC_RST_PTR 8'h00

// Pulse timing.
`define MCC_PULSE_MS 10
`define MCC_CLK_HZ 10000000

`endif

/* mcc_pkg.sv */
package mcc_pkg;
  typedef logic [7:0] mcc_byte_t;
  typedef enum logic [1:0] {
    MCC_PULSE_IDLE,
    MCC_PULSE_RESET,
    MCC_PULSE_CHASSIS
  } mcc_pulse_e;
endpackage

/* mcc_monitor_control.sv */
`timescale 1ns/1ps
`include "mcc_defs.svh"
module mcc_monitor_control #(
  parameter int CLK_HZ = `MCC_CLK_HZ,
  parameter int PULSE_MS = `MCC_PULSE_MS,
  parameter int CHAIN_W = 8,
  parameter logic [7:0] MFR_ID = 8'h5A, // Arbitrary identification value.
  parameter logic [7:0] REV_ID = 8'h01  // Arbitrary identification value.
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] stat1_event,
  input wire logic [7:0] stat2_event,
  input wire logic monitor_update,
  input wire logic test_select_input,
  input wire logic [CHAIN_W-1:0] chain_inputs,
  input wire logic chassis_intrusion_input,
  output logic monitor_run,
  output logic alarm_int_out,
  output logic alarm_int_oe,
  output logic general_output_pin,
  output logic general_output_oe,
  output logic shared_reset_overtemp_pin,
  output logic shared_reset_overtemp_oe,
  output logic chassis_clear_out,
  output logic chassis_clear_oe,
  output logic chain_test_output,
  output logic chain_test_mode,
  output logic irq
);

  // Pulse length in cycles, rounded up so the minimum is always met.
  localparam longint PULSE_CYC_L = (longint'(CLK_HZ) * PULSE_MS + 999) / 1000;
  localparam int PULSE_CYC = (PULSE_CYC_L < 1) ? 1 : int'(PULSE_CYC_L);
  localparam int CNT_W = $clog2(PULSE_CYC + 1);

  // Refused at elaboration: the pulse counters need at least one cycle per millisecond.
  if (CLK_HZ < 1000 || PULSE_MS < 1 || CHAIN_W < 1) begin : g_bad_params
    $error("mcc_monitor_control: unsupported parameter values");
  end

  mcc_pkg::mcc_byte_t cfg_q;
  mcc_pkg::mcc_byte_t stat1_q;
  mcc_pkg::mcc_byte_t stat2_q;
  mcc_pkg::mcc_byte_t mask1_q;
  mcc_pkg::mcc_byte_t mask2_q;
  mcc_pkg::mcc_byte_t fandiv_q;
  mcc_pkg::mcc_byte_t oscfg_q;
  mcc_pkg::mcc_byte_t convrate_q;
  mcc_pkg::mcc_byte_t chdis_q;
  mcc_pkg::mcc_byte_t ptr_q;
  mcc_pkg::mcc_byte_t ram_q [32];
  mcc_pkg::mcc_pulse_e pulse_q;
  logic [CNT_W-1:0] reset_cnt_q;
  logic [CNT_W-1:0] chassis_cnt_q;
  logic int_hold_q;
  logic [7:0] tgt;
  logic wr_cfg;
  logic init_req;
  logic rd_stat1;
  logic rd_stat2;
  logic rst_fn_en;
  logic int_active;
  logic reset_done;
  logic chassis_done;
  logic chain_level;

  // The pointer register is itself addressable; other accesses go where it points.
  assign tgt = (reg_addr == `MCC_ADDR_PTR) ? `MCC_ADDR_PTR : ptr_q;
  assign wr_cfg = reg_wr && (tgt == `MCC_ADDR_CONFIG);
  assign init_req = wr_cfg && reg_wdata[`MCC_CFG_INIT];
  assign rd_stat1 = reg_rd && (tgt == `MCC_ADDR_STAT1);
  assign rd_stat2 = reg_rd && (tgt == `MCC_ADDR_STAT2);
  assign rst_fn_en = fandiv_q[`MCC_FD_RST_EN] && !fandiv_q[`MCC_FD_OS_EN];
  assign reset_done = (pulse_q == mcc_pkg::MCC_PULSE_RESET) && (reset_cnt_q == '0);
  assign chassis_done = (chassis_cnt_q == CNT_W'(1));
  // Mask bit one keeps the matching status bit out of the interrupt.
  assign int_active = |(stat1_q & ~mask1_q) || |(stat2_q & ~mask2_q);
  // Chain NAND level toggles on every single input toggle from the all-ones state.
  assign chain_level = ~(&chain_inputs);

  // Pointer: written through its own offset, reset to zero.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_q <= `MCC_RST_PTR;
    end else if (reg_wr && reg_addr == `MCC_ADDR_PTR) begin
      ptr_q <= reg_wdata;
    end
  end

  // Configuration register; reset and chassis bits clear themselves when their pulse ends.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q <= `MCC_RST_CONFIG;
    end else if (init_req) begin
      cfg_q <= `MCC_RST_CONFIG;
    end else begin
      if (wr_cfg) begin
        cfg_q <= reg_wdata & 8'h7F;
      end
      if (!wr_cfg && reset_done) begin
        cfg_q[`MCC_CFG_RESET] <= 1'b0;
      end
      if (!wr_cfg && chassis_done) begin
        cfg_q[`MCC_CFG_CHASSIS] <= 1'b0;
      end
    end
  end

  // First mask register; the init bit restores it like a power-on.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask1_q <= `MCC_RST_MASK;
    end else if (init_req) begin
      mask1_q <= `MCC_RST_MASK;
    end else if (reg_wr && tgt == `MCC_ADDR_MASK1) begin
      mask1_q <= reg_wdata;
    end
  end

  // Second mask register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask2_q <= `MCC_RST_MASK;
    end else if (init_req) begin
      mask2_q <= `MCC_RST_MASK;
    end else if (reg_wr && tgt == `MCC_ADDR_MASK2) begin
      mask2_q <= reg_wdata;
    end
  end

  // Pin-function register; its top two bits choose what the shared pin does.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fandiv_q <= `MCC_RST_FANDIV;
    end else if (init_req) begin
      fandiv_q <= `MCC_RST_FANDIV;
    end else if (reg_wr && tgt == `MCC_ADDR_FANDIV) begin
      fandiv_q <= reg_wdata;
    end
  end

  // Overtemperature configuration, stored only; its modes live outside this block.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      oscfg_q <= `MCC_RST_OSCFG;
    end else if (init_req) begin
      oscfg_q <= `MCC_RST_OSCFG;
    end else if (reg_wr && tgt == `MCC_ADDR_OSCFG) begin
      oscfg_q <= reg_wdata;
    end
  end

  // Conversion rate, stored only.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      convrate_q <= `MCC_RST_CONVRATE;
    end else if (init_req) begin
      convrate_q <= `MCC_RST_CONVRATE;
    end else if (reg_wr && tgt == `MCC_ADDR_CONVRATE) begin
      convrate_q <= reg_wdata;
    end
  end

  // Channel disable, stored only.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chdis_q <= `MCC_RST_CHDIS;
    end else if (init_req) begin
      chdis_q <= `MCC_RST_CHDIS;
    end else if (reg_wr && tgt == `MCC_ADDR_CHDIS) begin
      chdis_q <= reg_wdata;
    end
  end

  // Status is set only while monitoring runs; a new event wins over a read-clear.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat1_q <= `MCC_RST_STAT;
      stat2_q <= `MCC_RST_STAT;
    end else if (init_req) begin
      stat1_q <= `MCC_RST_STAT;
      stat2_q <= `MCC_RST_STAT;
    end else begin
      stat1_q <= (rd_stat1 ? 8'h00 : stat1_q) | (monitor_run ? stat1_event : 8'h00);
      stat2_q <= (rd_stat2 ? 8'h00 : stat2_q) | (monitor_run ? (stat2_event & 8'h3F) : 8'h00);
    end
  end

  // After a read-clear the output stays low until the monitoring loop updates again.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_hold_q <= 1'b0;
    end else if (monitor_update && monitor_run) begin
      int_hold_q <= 1'b0;
    end else if (rd_stat1 || rd_stat2) begin
      int_hold_q <= 1'b1;
    end
  end

  // Value memory; two top locations carry non-zero power-on values.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 32; i++) begin
        ram_q[i] <= `MCC_RST_RAM;
      end
      ram_q[30] <= `MCC_RST_RAM_3E;
      ram_q[31] <= `MCC_RST_RAM_3F;
    end else if (reg_wr && tgt >= `MCC_ADDR_RAM_LO && tgt <= `MCC_ADDR_RAM_HI) begin
      ram_q[tgt[4:0]] <= reg_wdata;
    end
  end

  // Pulse sequencer: reset pulse needs the reset function enabled on the shared pin.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulse_q <= mcc_pkg::MCC_PULSE_IDLE;
      reset_cnt_q <= '0;
    end else begin
      case (pulse_q)
        mcc_pkg::MCC_PULSE_IDLE: begin
          if (cfg_q[`MCC_CFG_RESET] && rst_fn_en) begin
            pulse_q <= mcc_pkg::MCC_PULSE_RESET;
            reset_cnt_q <= CNT_W'(PULSE_CYC - 1);
          end
        end
        mcc_pkg::MCC_PULSE_RESET: begin
          if (reset_cnt_q == '0) begin
            pulse_q <= mcc_pkg::MCC_PULSE_IDLE;
          end else begin
            reset_cnt_q <= reset_cnt_q - CNT_W'(1);
          end
        end
        default: pulse_q <= mcc_pkg::MCC_PULSE_IDLE;
      endcase
    end
  end

  // Chassis clear runs its own counter so it can overlap a reset pulse.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chassis_cnt_q <= '0;
    end else if (chassis_cnt_q != '0) begin
      chassis_cnt_q <= chassis_cnt_q - CNT_W'(1);
    end else if (cfg_q[`MCC_CFG_CHASSIS]) begin
      chassis_cnt_q <= CNT_W'(PULSE_CYC);
    end
  end

  // Register read data, one cycle after the strobe.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (tgt)
        `MCC_ADDR_CONFIG: reg_rdata <= cfg_q;
        `MCC_ADDR_STAT1: reg_rdata <= stat1_q;
        `MCC_ADDR_STAT2: reg_rdata <= stat2_q;
        `MCC_ADDR_MASK1: reg_rdata <= mask1_q;
        `MCC_ADDR_MASK2: reg_rdata <= mask2_q;
        `MCC_ADDR_FANDIV: reg_rdata <= fandiv_q;
        `MCC_ADDR_OSCFG: reg_rdata <= oscfg_q;
        `MCC_ADDR_CONVRATE: reg_rdata <= convrate_q;
        `MCC_ADDR_CHDIS: reg_rdata <= chdis_q;
        `MCC_ADDR_MFR_ID: reg_rdata <= MFR_ID;
        `MCC_ADDR_REV_ID: reg_rdata <= REV_ID;
        `MCC_ADDR_PTR: reg_rdata <= ptr_q;
        default: begin
          if (tgt >= `MCC_ADDR_RAM_LO && tgt <= `MCC_ADDR_RAM_HI) begin
            reg_rdata <= ram_q[tgt[4:0]];
          end else begin
            reg_rdata <= 8'h00;
          end
        end
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Monitoring runs only with start set and interrupt-clear released.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      monitor_run <= 1'b0;
    end else begin
      monitor_run <= cfg_q[`MCC_CFG_START] && !cfg_q[`MCC_CFG_INT_CLR];
    end
  end

  // Interrupt pin: the start bit plays no part here, so shutdown keeps the pin as is.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_int_out <= 1'b0;
      alarm_int_oe <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq <= int_active && !int_hold_q && cfg_q[`MCC_CFG_INT_EN]
             && !cfg_q[`MCC_CFG_INT_CLR];
      alarm_int_out <= cfg_q[`MCC_CFG_INT_POL];
      // High polarity sources a high; low polarity sinks a low, else the pin floats.
      alarm_int_oe <= int_active && !int_hold_q && cfg_q[`MCC_CFG_INT_EN]
                      && !cfg_q[`MCC_CFG_INT_CLR];
    end
  end

  // General output is open-drain: the pin value is always low, only the enable moves.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      general_output_pin <= 1'b0;
      general_output_oe <= 1'b0;
    end else begin
      general_output_pin <= 1'b0;
      general_output_oe <= cfg_q[`MCC_CFG_GPO];
    end
  end

  // Shared pin sinks low only while a reset pulse runs with its function selected.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shared_reset_overtemp_pin <= 1'b0;
      shared_reset_overtemp_oe <= 1'b0;
    end else begin
      shared_reset_overtemp_pin <= 1'b0;
      shared_reset_overtemp_oe <= (pulse_q == mcc_pkg::MCC_PULSE_RESET) && rst_fn_en;
    end
  end

  // Chassis input is pulled low while its clear counter runs.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chassis_clear_out <= 1'b0;
      chassis_clear_oe <= 1'b0;
    end else begin
      chassis_clear_out <= 1'b0;
      chassis_clear_oe <= (chassis_cnt_q != '0);
    end
  end

  // Chain test: the lowest address pin is driven only while test-select is low.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chain_test_mode <= 1'b0;
    end else begin
      chain_test_mode <= !test_select_input;
    end
  end

  // Chain level runs all the time; the pad only shows it in test mode.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chain_test_output <= 1'b0;
    end else begin
      chain_test_output <= chain_level ^ chassis_intrusion_input;
    end
  end

endmodule

/* mcc_monitor_assertions.sv */
`timescale 1ns/1ps
module mcc_monitor_checker #(
  parameter int CLK_HZ = 1000,
  parameter int PULSE_MS = 1,
  parameter int CHAIN_W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq,
  input wire logic alarm_int_oe,
  input wire logic general_output_pin,
  input wire logic general_output_oe,
  input wire logic shared_reset_overtemp_oe,
  input wire logic chassis_clear_oe,
  input wire logic test_select_input,
  input wire logic [CHAIN_W-1:0] chain_inputs,
  input wire logic chassis_intrusion_input,
  input wire logic chain_test_output,
  input wire logic chain_test_mode
);
  localparam int PCYC = (CLK_HZ * PULSE_MS + 999) / 1000;
  logic [1:0] up_q;
  int rst_len_q;
  int chs_len_q;
  // Look-back checks wait until inputs seen during reset have aged out.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      up_q <= 2'h0;
    end else if (up_q != 2'h3) begin
      up_q <= up_q + 2'h1;
    end
  end
  // Lengths of the running pulses in clock cycles.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_len_q <= 0;
      chs_len_q <= 0;
    end else begin
      rst_len_q <= shared_reset_overtemp_oe ? rst_len_q + 1 : 0;
      chs_len_q <= chassis_clear_oe ? chs_len_q + 1 : 0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence pulse_end_s(s);
    $fell(s);
  endsequence
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  int_gate_a: assert property (alarm_int_oe == irq)
    else $error("interrupt pin and level disagree");
  gpo_low_a: assert property (general_output_oe |-> !general_output_pin)
    else $error("general output driven high");
  gpo_cause_a: assert property ($rose(general_output_oe) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("general output changed without a write");
  chain_mode_a: assert property (up_q == 2'h3 |-> chain_test_mode == !$past(test_select_input))
    else $error("chain test mode wrong");
  chain_out_a: assert property (up_q == 2'h3 && !$past(test_select_input) |->
    chain_test_output == ((~&$past(chain_inputs)) ^ $past(chassis_intrusion_input)))
    else $error("chain output wrong");
  rst_len_a: assert property (pulse_end_s(shared_reset_overtemp_oe) |-> rst_len_q == PCYC)
    else $error("reset pulse length wrong");
  chs_len_a: assert property (pulse_end_s(chassis_clear_oe) |-> chs_len_q == PCYC)
    else $error("chassis clear length wrong");
endmodule

bind mcc_monitor_control mcc_monitor_checker #(.CLK_HZ(CLK_HZ), .PULSE_MS(PULSE_MS),
  .CHAIN_W(CHAIN_W)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq(irq), .alarm_int_oe(alarm_int_oe), .general_output_pin(general_output_pin),
  .general_output_oe(general_output_oe), .shared_reset_overtemp_oe(shared_reset_overtemp_oe),
  .chassis_clear_oe(chassis_clear_oe), .test_select_input(test_select_input),
  .chain_inputs(chain_inputs), .chassis_intrusion_input(chassis_intrusion_input),
  .chain_test_output(chain_test_output), .chain_test_mode(chain_test_mode)
);

/* mcc_host_model.sv */
`timescale 1ns/1ps
module mcc_host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // Quiet bus from time zero.
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // A strobe is dropped at its edge and never raised in the same step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // Released data must not look valid.
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // The pointer is loaded first to choose the target.
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    wr(8'h0F, a);
    wr(8'h00, d);
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    wr(8'h0F, a);
    rd(8'h00, d);
  endtask
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  localparam int CLK_HZ = 1000;
  localparam int PULSE_MS = 4;
  localparam int PCYC = (CLK_HZ * PULSE_MS + 999) / 1000;
  logic clk, sys_rst, reg_wr, reg_rd, monitor_update, test_select_input;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, stat1_event, stat2_event, chain_inputs;
  logic chassis_intrusion_input, monitor_run, alarm_int_out, alarm_int_oe, irq;
  logic general_output_pin, general_output_oe, shared_reset_overtemp_pin;
  logic shared_reset_overtemp_oe, chassis_clear_out, chassis_clear_oe;
  logic chain_test_output, chain_test_mode;
  int n_fail, tests_run, cyc, seed;
  logic [7:0] v, d, st1;
  logic [7:0] dlist [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h08, 8'h3E, 8'h3F};
  mcc_monitor_control #(.CLK_HZ(CLK_HZ), .PULSE_MS(PULSE_MS)) dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stat1_event(stat1_event), .stat2_event(stat2_event), .monitor_update(monitor_update),
    .test_select_input(test_select_input), .chain_inputs(chain_inputs),
    .chassis_intrusion_input(chassis_intrusion_input), .monitor_run(monitor_run),
    .alarm_int_out(alarm_int_out), .alarm_int_oe(alarm_int_oe),
    .general_output_pin(general_output_pin), .general_output_oe(general_output_oe),
    .shared_reset_overtemp_pin(shared_reset_overtemp_pin),
    .shared_reset_overtemp_oe(shared_reset_overtemp_oe),
    .chassis_clear_out(chassis_clear_out), .chassis_clear_oe(chassis_clear_oe),
    .chain_test_output(chain_test_output), .chain_test_mode(chain_test_mode), .irq(irq)
  );
  mcc_host_model host (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );
  // Free-running clock at 100 ns.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // A hang ends the run as a failure.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      final_report();
    end
  end
  function automatic logic [7:0] dflt(input logic [7:0] a);
    case (a)
      8'h00: return 8'h08;
      8'h05: return 8'h14;
      8'h06, 8'h3E: return 8'h01;
      8'h3F: return 8'h08;
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic defaults();
    for (int i = 0; i < 11; i++) begin
      host.get(dlist[i], d);
      chk("default", d, dflt(dlist[i]));
    end
  endtask
  task automatic ev(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    stat1_event <= a;
    stat2_event <= b;
    @(posedge clk);
    stat1_event <= 8'h00;
    stat2_event <= 8'h00;
    settle(3);
  endtask
  // One pass of the monitoring loop; it ends the hold left by a status read.
  task automatic upd();
    @(posedge clk);
    monitor_update <= 1'b1;
    @(posedge clk);
    monitor_update <= 1'b0;
    settle(3);
  endtask
  // Counts the drive cycles of one timed pin and reads the bit back.
  task automatic pulse_run(input logic [7:0] cfg, input int bitn, input logic want);
    int hi;
    hi = 0;
    host.put(8'h00, cfg);
    repeat (PCYC + 6) begin
      @(posedge clk);
      #1 if ((bitn == 4 ? shared_reset_overtemp_oe : chassis_clear_oe) === 1'b1) hi++;
    end
    host.get(8'h00, d);
    chk("pulse_len", 8'(hi), want ? 8'(PCYC) : 8'h00);
    chk("self_clear", d[bitn], !want);
    chk("rst_pin", shared_reset_overtemp_pin, 1'b0);
    chk("chs_pin", chassis_clear_out, 1'b0);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence; a second reset near the end repeats the default checks.
  initial begin
    seed = 32'h7153;
    sys_rst = 1'b1;
    {stat1_event, stat2_event, monitor_update, chassis_intrusion_input} = '0;
    test_select_input = 1'b1;
    chain_inputs = 8'hFF;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    host.rd(8'h0F, d);
    chk("pointer", d, 8'h00);
    defaults();
    v = 8'($random(seed));
    host.put(8'h25, v);
    host.get(8'h25, d);
    chk("value_mem", d, v);
    host.put(8'h10, 8'hA5);
    host.get(8'h10, d);
    chk("unmapped", d, 8'h00);
    host.put(8'h01, 8'hFF);
    host.get(8'h01, d);
    chk("stat_ro", d, 8'h00);
    host.put(8'h00, 8'h07);
    settle(2);
    chk("run", monitor_run, 1'b1);
    upd();
    st1 = 8'($random(seed)) | 8'h01;
    ev(st1, 8'h00);
    chk("irq", irq, 1'b1);
    chk("int_out", alarm_int_out, 1'b1);
    host.get(8'h01, d);
    chk("stat1", d, st1);
    settle(2);
    chk("irq_rd", irq, 1'b0);
    host.get(8'h01, d);
    chk("stat1_clr", d, 8'h00);
    st1 = 8'($random(seed)) | 8'h02;
    ev(st1, 8'h00);
    chk("irq_hold", irq, 1'b0);
    upd();
    chk("irq_upd", irq, 1'b1);
    host.put(8'h03, 8'hFF);
    settle(2);
    chk("irq_mask", irq, 1'b0);
    host.put(8'h03, 8'h00);
    ev(8'h00, 8'hFF);
    host.put(8'h00, 8'h03);
    settle(2);
    chk("int_low", alarm_int_out, 1'b0);
    host.put(8'h00, 8'h02);
    settle(2);
    chk("run_off", monitor_run, 1'b0);
    chk("irq_stop", irq, 1'b1);
    host.put(8'h00, 8'h0B);
    settle(2);
    chk("irq_clr", irq, 1'b0);
    chk("run_clr", monitor_run, 1'b0);
    ev(8'h80, 8'h00);
    host.put(8'h00, 8'h03);
    settle(2);
    chk("irq_back", irq, 1'b1);
    host.put(8'h00, 8'h01);
    settle(2);
    chk("irq_dis", alarm_int_oe, 1'b0);
    host.get(8'h02, d);
    chk("stat2", d, 8'h3F);
    host.get(8'h01, d);
    chk("stat1_kept", d, st1);
    host.put(8'h00, 8'h40);
    settle(2);
    chk("gpo_oe", general_output_oe, 1'b1);
    host.put(8'h05, 8'h94);
    pulse_run(8'h10, 4, 1'b1);
    pulse_run(8'h20, 5, 1'b1);
    host.put(8'h05, 8'hD4);
    pulse_run(8'h10, 4, 1'b0);
    host.put(8'h03, 8'h5A);
    host.put(8'h07, 8'h33);
    host.put(8'h00, 8'h80);
    defaults();
    host.get(8'h25, d);
    chk("mem_kept", d, v);
    @(posedge clk);
    test_select_input <= 1'b0;
    // Chain pins leave the all-ones state one at a time, then at random.
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      v = (i < 8) ? (8'hFF ^ (8'h01 << i)) : 8'($random(seed));
      chain_inputs <= v;
      chassis_intrusion_input <= v[3] ^ v[5];
      settle(2);
      chk("chain_mode", chain_test_mode, 1'b1);
      chk("chain_out", chain_test_output, (~&v) ^ v[3] ^ v[5]);
    end
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    defaults();
    final_report();
  end
endmodule
